/* dv/slow_scan_ground_station_sequencer_tb_top.sv */
// Testbench joining both ends of the slow-scan link
`timescale 1ns/1ns
`default_nettype none
module slow_scan_ground_station_sequencer_tb_top;
   logic       mclk;
   logic       sys_rst;
   logic [2:0] rate_sel;
   logic       hold_req;
   logic       hold_cmd;
   logic       reset_hold_cmd;
   logic [7:0] cam_video;
   logic [1:0] write_mode;
   logic [1:0] read_mode;
   logic [1:0] erase_mode;
   logic [1:0] sync_master;
   logic       sweep_en;
   logic [7:0] write_video;
   logic       write_video_valid;
   logic [2:0] sweep_rate;
   logic       held;
   logic       busy;
   int         n_mismatch = 0;
   int         comparisons = 0;

   ssg_link_if link ();
   ssg_air_tx #(.FRAME_CYC(100), .BURST_CYC(5), .LINE_CYC(20))
      i_ssg_air_tx (.mclk, .sys_rst, .link, .rate_sel, .hold_req,
      .cam_video, .busy);
   ssg_ground_seq #(.FIELD_CYC(50)) i_ssg_ground_seq (.mclk, .sys_rst,
      .link, .rate_sel, .hold_cmd, .reset_hold_cmd, .write_mode,
      .read_mode, .erase_mode, .sync_master, .sweep_en, .write_video,
      .write_video_valid, .sweep_rate, .held);
   ssg_link_chk #(.FIELD_CYC(50)) i_ssg_link_chk (.mclk, .sys_rst,
      .burst(link.burst), .hblank(link.hblank), .video(link.video),
      .video_valid(link.video_valid), .reset_hold_cmd, .write_mode,
      .read_mode, .erase_mode, .sync_master, .sweep_en, .write_video,
      .write_video_valid, .sweep_rate, .held);

   // ----------------------------------------
   // Clock, stimulus helpers and verdict
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   always @(negedge mclk) begin
      cam_video <= cam_video + 8'h01;
   end

   task automatic chk(input string name, input logic [7:0] exp,
                      input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s exp %h got %h", name, exp, got);
      end
   endtask

   // Bounded waits; a frame at the slowest rate used fits well inside
   task automatic wait_wr(input logic [1:0] v);
      int n;
      n = 0;
      while (write_mode !== v && n < 40000) begin
         @(negedge mclk);
         n++;
      end
      chk("write_mode", {6'h00, v}, {6'h00, write_mode});
   endtask

   task automatic wait_sweep();
      int n;
      n = 0;
      while (sweep_en !== 1'b1 && n < 40000) begin
         @(negedge mclk);
         n++;
      end
      chk("sweep_en", 8'h01, {7'h00, sweep_en});
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 40000) begin
         @(negedge mclk);
         n++;
      end
      chk("busy", 8'h00, {7'h00, busy});
   endtask

   task automatic give_verdict();
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Five frames take under 80000 cycles; allow some slack
   initial begin
      #(100000 * 100);
      n_mismatch++;
      give_verdict();
   end

   initial begin
      sys_rst = 1'b1;
      rate_sel = 3'h1;
      hold_req = 1'b0;
      hold_cmd = 1'b0;
      reset_hold_cmd = 1'b0;
      cam_video = 8'h00;
      repeat (8) @(negedge mclk);
      sys_rst = 1'b0;
      @(negedge mclk);
      chk("erase_mode", 8'h03, {6'h00, erase_mode});
      chk("read_mode", 8'h00, {6'h00, read_mode});
      chk("busy", 8'h01, {7'h00, busy});
      wait_wr(2'b01);
      wait_sweep();
      chk("sweep_rate", 8'h01, {5'h00, sweep_rate});
      rate_sel = 3'h0;
      wait_wr(2'b00);
      chk("read_mode", 8'h01, {6'h00, read_mode});
      chk("sync_master", 8'h01, {6'h00, sync_master});
      chk("erase_mode", 8'h02, {6'h00, erase_mode});
      wait_wr(2'b10);
      chk("sweep_rate", 8'h00, {5'h00, sweep_rate});
      hold_cmd = 1'b1;
      @(negedge mclk);
      hold_cmd = 1'b0;
      wait_wr(2'b00);
      chk("read_mode", 8'h02, {6'h00, read_mode});
      chk("sync_master", 8'h02, {6'h00, sync_master});
      chk("erase_mode", 8'h01, {6'h00, erase_mode});
      chk("held", 8'h01, {7'h00, held});
      // Far end still sends a frame; its burst must be ignored
      repeat (1000) @(negedge mclk);
      chk("write_mode", 8'h00, {6'h00, write_mode});
      chk("held", 8'h01, {7'h00, held});
      hold_req = 1'b1;
      wait_idle();
      hold_req = 1'b0;
      rate_sel = 3'h7;
      reset_hold_cmd = 1'b1;
      @(negedge mclk);
      reset_hold_cmd = 1'b0;
      rate_sel = 3'h0;
      chk("write_mode", 8'h01, {6'h00, write_mode});
      chk("held", 8'h00, {7'h00, held});
      chk("sweep_rate", 8'h05, {5'h00, sweep_rate});
      wait_sweep();
      wait_wr(2'b00);
      chk("read_mode", 8'h01, {6'h00, read_mode});
      give_verdict();
   end
endmodule
`default_nettype wire

/* dv/ssg_link_chk.sv */
// Assertions on the link and the ground sequencer outputs
`timescale 1ns/1ns
`default_nettype none
module ssg_link_chk #(
   parameter int unsigned FIELD_CYC = ssg_pkg::FIELD_CYC_32
) (
   input wire logic       mclk,
   input wire logic       sys_rst,
   input wire logic       burst,
   input wire logic       hblank,
   input wire logic       video_valid,
   input wire logic [7:0] video,
   input wire logic       reset_hold_cmd,
   input wire logic [1:0] write_mode,
   input wire logic [1:0] read_mode,
   input wire logic [1:0] erase_mode,
   input wire logic [1:0] sync_master,
   input wire logic       sweep_en,
   input wire logic [7:0] write_video,
   input wire logic       write_video_valid,
   input wire logic [2:0] sweep_rate,
   input wire logic       held
);
   logic        hb_ff;
   logic [9:0]  line_ff;
   int unsigned er_ff;

   // ----------------------------------------
   // Line and erase counters
   // ----------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         hb_ff <= 1'b0;
      end else begin
         hb_ff <= hblank;
      end
   end

   // Cleared while idle, so a partial frame never leaks in
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         line_ff <= 10'h000;
      end else if (write_mode == 2'b00) begin
         line_ff <= 10'h000;
      end else if (hblank && !hb_ff) begin
         line_ff <= line_ff + 10'h001;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         er_ff <= 32'h0000_0000;
      end else if (erase_mode[1]) begin
         er_ff <= er_ff + 32'h0000_0001;
      end else begin
         er_ff <= 32'h0000_0000;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   AST_WR_CAUSE: assert property (
      $rose(|write_mode) |-> $past(burst) || $past(reset_hold_cmd))
      else $error("write started without burst or reset hold");
   AST_ONE_TARGET: assert property (
      write_mode != 2'b11 && (write_mode & read_mode) == 2'b00)
      else $error("converter roles overlap");
   AST_MASTER: assert property (
      read_mode != 2'b00 |-> sync_master == read_mode)
      else $error("displayed unit is not sync master");
   AST_STRIP: assert property (
      $rose(sweep_en) |-> line_ff == ssg_pkg::BLANK_LINES)
      else $error("sweep enabled after wrong blank count");
   AST_SWEEP_IN_WRITE: assert property (
      sweep_en |-> write_mode != 2'b00)
      else $error("sweep enabled outside write");
   AST_DONE_COUNT: assert property (
      $fell(|write_mode) |->
         line_ff == ssg_pkg::BLANK_LINES + ssg_pkg::VIDEO_LINES)
      else $error("write ended at wrong line count");
   AST_SWAP: assert property (
      $fell(|write_mode) |-> read_mode == $past(write_mode) &&
         (erase_mode & ~read_mode) == ~read_mode)
      else $error("completion did not swap display and erase");
   AST_ERASE_LEN: assert property (
      $fell(erase_mode[1]) |->
         er_ff >= 11 * FIELD_CYC && er_ff <= 12 * FIELD_CYC)
      else $error("erase length off");
   AST_VIDEO_PASS: assert property (
      sweep_en && video_valid |=>
         write_video_valid && write_video == $past(video))
      else $error("video not passed to converter");
   AST_RATE: assert property (
      sweep_en |-> sweep_rate <= 3'h5)
      else $error("sweep rate out of range");
   AST_HELD_IDLE: assert property (
      held |-> write_mode == 2'b00)
      else $error("writing while held");

   cover property ($fell(|write_mode));
   cover property ($rose(held));
   cover property (held && reset_hold_cmd);
endmodule
`default_nettype wire

/* include/ssg_link_if.sv */
// Link between the airborne processor and the ground sequencer
`timescale 1ns/1ns
`default_nettype none
interface ssg_link_if;
   logic burst;
   logic hblank;
   logic video_valid;
   logic [7:0] video;

   modport air (
      output burst,
      output hblank,
      output video_valid,
      output video
   );
   modport ground (
      input  burst,
      input  hblank,
      input  video_valid,
      input  video
   );
endinterface
`default_nettype wire

/* include/ssg_pkg.sv */
// Shared constants and types for the slow-scan ground sequencer link
`default_nettype none
package ssg_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ           = 10_000_000;
   localparam int unsigned FRAME_TIME_US    = 33_333;
   localparam int unsigned FRAME_CYC_32     =
      (FRAME_TIME_US * (CLK_HZ / 1_000_000));
   localparam int unsigned FIELD_CYC_32     = FRAME_CYC_32 / 2;
   localparam int unsigned BURST_TIME_US    = 100;
   localparam int unsigned BURST_CYC_32     =
      (BURST_TIME_US * (CLK_HZ / 1_000_000));

   // ------------------------------------------------------------
   // Counts
   // ------------------------------------------------------------
   localparam logic [9:0] BLANK_LINES       = 10'h025;
   localparam logic [9:0] VIDEO_LINES       = 10'h1E8;
   localparam logic [3:0] ERASE_FIELDS      = 4'h0B;
   localparam logic [2:0] POST_FRAMES       = 3'h4;
   localparam logic [2:0] PRE_FRAMES        = 3'h2;
   localparam logic [2:0] RATE_COUNT        = 3'h6;
   localparam logic [2:0] RATE_RESET        = 3'h0;
   localparam logic [15:0] LINE_PER_RATE_0  = 16'h0A00;

   typedef logic [2:0] ssg_rate_t;

endpackage
`default_nettype wire

/* rtl/ssg_air_tx.sv */
// Airborne end: frame cycle sequencer driving the link
`timescale 1ns/1ns
`default_nettype none
module ssg_air_tx #(
   parameter int unsigned FRAME_CYC = ssg_pkg::FRAME_CYC_32,
   parameter int unsigned BURST_CYC = ssg_pkg::BURST_CYC_32,
   parameter int unsigned LINE_CYC  = 32'(ssg_pkg::LINE_PER_RATE_0)
) (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   ssg_link_if.air          link,
   input  wire logic [2:0]  rate_sel,
   input  wire logic        hold_req,
   input  wire logic [7:0]  cam_video,
   output logic             busy
);

   // ------------------------------------------------------------
   // Cycle states
   // ------------------------------------------------------------
   typedef enum {A_PRIME, A_WRITE, A_BURST, A_PRE, A_BLANK, A_VIDEO,
                 A_POST, A_HOLD} ssg_air_e;
   ssg_air_e state_ff;

   logic [31:0] tmr_ff;
   logic [9:0]  line_ff;
   logic [2:0]  fr_ff;
   logic [31:0] line_len;
   logic [7:0]  store_ff;
   logic [2:0]  rate_ff;

   // Six slow rates; higher code aliases to the slowest
   always_comb begin
      line_len = LINE_CYC << (rate_ff > 3'h5 ? 3'h5 : rate_ff);
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rate_ff <= ssg_pkg::RATE_RESET;
      end else if (state_ff == A_PRIME) begin
         rate_ff <= rate_sel;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= A_PRIME;
         tmr_ff   <= 32'h0000_0000;
         line_ff  <= 10'h000;
         fr_ff    <= 3'h0;
      end else begin
         tmr_ff <= tmr_ff + 32'h0000_0001;
         unique case (state_ff)
            A_PRIME: if (tmr_ff >= FRAME_CYC - 1) begin
               state_ff <= A_WRITE;
               tmr_ff   <= 32'h0000_0000;
            end
            A_WRITE: if (tmr_ff >= FRAME_CYC - 1) begin
               state_ff <= A_BURST;
               tmr_ff   <= 32'h0000_0000;
            end
            A_BURST: if (tmr_ff >= BURST_CYC - 1) begin
               state_ff <= A_PRE;
               tmr_ff   <= 32'h0000_0000;
            end
            A_PRE: if (tmr_ff >= PRE_CYC() - 1) begin
               state_ff <= A_BLANK;
               tmr_ff   <= 32'h0000_0000;
               line_ff  <= 10'h000;
            end
            A_BLANK, A_VIDEO: if (tmr_ff >= line_len - 1) begin
               tmr_ff  <= 32'h0000_0000;
               line_ff <= line_ff + 10'h001;
               if (state_ff == A_BLANK &&
                   line_ff == ssg_pkg::BLANK_LINES - 10'h001) begin
                  state_ff <= A_VIDEO;
                  line_ff  <= 10'h000;
               end else if (state_ff == A_VIDEO &&
                   line_ff == ssg_pkg::VIDEO_LINES - 10'h001) begin
                  state_ff <= A_POST;
                  fr_ff    <= 3'h0;
               end
            end
            A_POST: if (tmr_ff >= FRAME_CYC - 1) begin
               tmr_ff <= 32'h0000_0000;
               fr_ff  <= fr_ff + 3'h1;
               if (fr_ff == ssg_pkg::POST_FRAMES - 3'h1) begin
                  state_ff <= hold_req ? A_HOLD : A_PRIME;
               end
            end
            A_HOLD: begin
               tmr_ff <= 32'h0000_0000;
               if (!hold_req) begin
                  state_ff <= A_PRIME;
               end
            end
         endcase
      end
   end

   function automatic logic [31:0] PRE_CYC();
      PRE_CYC = FRAME_CYC * 32'(ssg_pkg::PRE_FRAMES);
   endfunction

   // Stored picture sample; held frozen in hold, fields merged upstream
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         store_ff <= 8'h00;
      end else if (state_ff == A_WRITE) begin
         store_ff <= cam_video;
      end
   end

   always_comb begin
      link.burst       = (state_ff == A_BURST);
      link.hblank      = (state_ff == A_BLANK || state_ff == A_VIDEO) &&
                         (tmr_ff == 32'h0000_0000);
      link.video_valid = (state_ff == A_VIDEO);
      link.video       = (state_ff == A_VIDEO) ? store_ff : 8'h00;
      busy             = (state_ff != A_HOLD);
   end

endmodule
`default_nettype wire

/* rtl/ssg_ground_seq.sv */
// Ground end: burst detect, line strip and converter ping-pong control
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Power-up erases both converters, picks one first
// - Far end opens each frame with burst
// - Far end sends gap, 37 blank, 488 lines
// - Far end waits four frame times after video
// - Burst starts write logic, target into write
// - Strip first 37 line pulses, then write
// - Sweep slope follows six-way rate selector
// - After 488 lines converter goes to display
// - Converters alternate write and display roles
// - Displayed unit is master, other slaves sync
// - Finished write starts 11-field erase on other
// - Hold after frame ends, stop seeking bursts
// - Reset-hold acts like burst while held
// - Far end cycles prime, write, sync, read
// - Far end times cycles by frame pulses
// - Far end hold freezes last stored frame
// - Far end read rate from 3-bit select
module ssg_ground_seq #(
   parameter int unsigned FIELD_CYC = ssg_pkg::FIELD_CYC_32
) (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   ssg_link_if.ground       link,
   input  wire logic [2:0]  rate_sel,
   input  wire logic        hold_cmd,
   input  wire logic        reset_hold_cmd,
   output logic [1:0]       write_mode,
   output logic [1:0]       read_mode,
   output logic [1:0]       erase_mode,
   output logic [1:0]       sync_master,
   output logic             sweep_en,
   output logic [7:0]       write_video,
   output logic             write_video_valid,
   output logic [2:0]       sweep_rate,
   output logic             held
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum {G_BOOT, G_SEEK, G_STRIP, G_WRITE, G_HOLD} ssg_gnd_e;
   ssg_gnd_e state_ff;

   logic [9:0] blank_ff;
   logic [9:0] line_ff;
   logic       target_ff;
   logic       shown_ff;
   logic       shown_ok_ff;
   logic [1:0] erase_ff;
   logic [3:0] fld_ff [2];
   logic [31:0] tmr_ff;
   logic       hold_pend_ff;
   logic [2:0] rate_ff;
   logic       start;
   logic       done;
   logic       hb_prev_ff;
   logic       hb_rise;

   assign hb_rise = link.hblank && !hb_prev_ff;
   // Reset-hold stands in for the burst only while held
   assign start = (state_ff == G_SEEK && link.burst) ||
                  (state_ff == G_HOLD && reset_hold_cmd);
   assign done  = (state_ff == G_WRITE) && hb_rise &&
                  (line_ff == ssg_pkg::VIDEO_LINES - 10'h001);

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         hb_prev_ff <= 1'b0;
      end else begin
         hb_prev_ff <= link.hblank;
      end
   end

   // ------------------------------------------------------------
   // Frame sequence
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= G_BOOT;
         blank_ff <= 10'h000;
         line_ff  <= 10'h000;
      end else begin
         unique case (state_ff)
            G_BOOT: if (erase_ff == 2'b00) begin
               state_ff <= G_SEEK;
            end
            G_SEEK, G_HOLD: if (start) begin
               state_ff <= G_STRIP;
               blank_ff <= 10'h000;
               line_ff  <= 10'h000;
            end
            G_STRIP: if (hb_rise) begin
               blank_ff <= blank_ff + 10'h001;
               if (blank_ff == ssg_pkg::BLANK_LINES - 10'h001) begin
                  state_ff <= G_WRITE;
               end
            end
            G_WRITE: if (hb_rise) begin
               line_ff <= line_ff + 10'h001;
               if (done) begin
                  state_ff <= (hold_pend_ff || hold_cmd) ? G_HOLD
                                                         : G_SEEK;
               end
            end
         endcase
      end
   end

   // Hold request latched; takes effect only at frame end
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         hold_pend_ff <= 1'b0;
      end else if (hold_cmd) begin
         hold_pend_ff <= 1'b1;
      end else if (state_ff == G_HOLD) begin
         hold_pend_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Converter roles
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         target_ff   <= 1'b0;
         shown_ff    <= 1'b1;
         shown_ok_ff <= 1'b0;
      end else if (done) begin
         shown_ff    <= target_ff;
         target_ff   <= ~target_ff;
         shown_ok_ff <= 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rate_ff <= ssg_pkg::RATE_RESET;
      end else if (start) begin
         rate_ff <= (rate_sel > 3'h5) ? 3'h5 : rate_sel;
      end
   end

   // Field timer shared by both erase counters
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         tmr_ff <= 32'h0000_0000;
      end else if (tmr_ff >= FIELD_CYC - 1) begin
         tmr_ff <= 32'h0000_0000;
      end else begin
         tmr_ff <= tmr_ff + 32'h0000_0001;
      end
   end

   // Erase runs a fixed field count; a field in progress may add one
   for (genvar u = 0; u < 2; u++) begin : g_unit
      always_ff @(posedge mclk or posedge sys_rst) begin
         if (sys_rst) begin
            fld_ff[u]   <= ssg_pkg::ERASE_FIELDS;
            erase_ff[u] <= 1'b1;
         end else if (done && u != int'(target_ff)) begin
            fld_ff[u]   <= ssg_pkg::ERASE_FIELDS;
            erase_ff[u] <= 1'b1;
         end else if (erase_ff[u] && tmr_ff == 32'h0000_0000) begin
            // Ends on the twelfth field tick, so eleven whole fields run
            if (fld_ff[u] == 4'h0) begin
               erase_ff[u] <= 1'b0;
            end else begin
               fld_ff[u] <= fld_ff[u] - 4'h1;
            end
         end
      end

      always_comb begin
         write_mode[u]  = (state_ff == G_STRIP || state_ff == G_WRITE) &&
                          (u == int'(target_ff));
         read_mode[u]   = shown_ok_ff && (u == int'(shown_ff));
         erase_mode[u]  = erase_ff[u];
         sync_master[u] = (u == int'(shown_ff));
      end
   end

   // ------------------------------------------------------------
   // Write path
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         write_video       <= 8'h00;
         write_video_valid <= 1'b0;
      end else begin
         write_video       <= link.video;
         write_video_valid <= (state_ff == G_WRITE) && link.video_valid;
      end
   end

   always_comb begin
      sweep_en   = (state_ff == G_WRITE);
      sweep_rate = rate_ff;
      held       = (state_ff == G_HOLD);
   end

endmodule
`default_nettype wire
